// *** core/sleep_wakeup_interrupt_ctrl.sv ***
// sleep entry, pin wakeup, two-source interrupt control and save buffer
// assumes the core's byte register port, a core_clk that keeps running in sleep,
// and a timer and sequencer on the same clock giving one-cycle event pulses
// the wake watch needs no oscillator: it runs on the always-on clock
// writes count only while the core runs; reads are served in any mode
module sleep_wakeup_interrupt_ctrl
(
    input  wire logic                 core_clk,
    input  wire logic                 rst_b,
    input  wire swi_pkg::reg_bus_t    reg_bus,
    output logic [7:0]                reg_rdata,
    input  wire logic                 port0_pin,
    input  wire logic [5:0]           port1_pins,
    input  wire logic                 timer_overflow,
    input  wire swi_pkg::core_evt_t   core_evt,
    output swi_pkg::vector_t          vector_out,
    output swi_pkg::restore_t         restore_out,
    output logic                      osc_run,
    output logic                      cpu_run
);

    // all state of the block outside the pin filter and wake watch in one record
    typedef struct packed
    {
        swi_pkg::mode_t                   mode;
        logic                             sleep_bit;
        logic [5:0]                       p1_wake;
        logic [1:0]                       edge_sel;
        logic                             ext_en;
        logic                             tmr_en;
        logic                             ext_flag;
        logic                             tmr_flag;
        logic                             global_irq_enable;
        logic [1:0]                       stk;
        logic [swi_pkg::WAKE_CNT_W-1:0]   cnt;
        logic                             pin0_prev;
        logic [7:0]                       rdata;
        logic [7:0]                       save_acc;
        logic [7:0]                       save_flags;
        swi_pkg::restore_t                restore;
        swi_pkg::vector_t                 vec;
    } ctrl_t;

    // registered state and its next value
    ctrl_t                        st_r;
    ctrl_t                        st_nxt;

    // nets between helper logic and the state update
    logic [swi_pkg::PIN_W-1:0]    pins_q;
    logic                         wake_hit;
    logic                         enter_sleep;
    logic                         ext_edge;
    logic                         pend;
    logic                         accept;
    logic                         normal;

    // address match used by both write and read decode
    function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
        hit = (a == target);
    endfunction

    // pin synchroniser for port 0 pin 0 and port 1
    // filtered levels lag the pins by four edges
    pin_sync u_sync
    (
        .core_clk   (core_clk),
        .rst_b      (rst_b),
        .pins_async ({port1_pins, port0_pin}),
        .pins_q     (pins_q)
    );

    // level change watcher running on the always-on clock
    // reference levels are caught on the sleep entry write
    wake_detect u_wake
    (
        .core_clk   (core_clk),
        .rst_b      (rst_b),
        .pins_q     (pins_q),
        .p1_wake_en (st_r.p1_wake),
        .capture    (enter_sleep),
        .wake_hit   (wake_hit)
    );

    // the core executes only in normal mode
    assign normal = (st_r.mode == swi_pkg::MODE_NORMAL);

    // software sets the sleep bit only while running
    assign enter_sleep = normal && reg_bus.wr
                         && hit(reg_bus.addr, swi_pkg::ADDR_OSC_CTRL)
                         && reg_bus.wdata[swi_pkg::SLEEP_BIT];

    // selected edge on port 0 pin 0
    always_comb
    begin
        // the previous level is the filtered pin one cycle earlier
        case (st_r.edge_sel)
            swi_pkg::EDGE_RISE:
            begin
                ext_edge = pins_q[0] && !st_r.pin0_prev;
            end
            swi_pkg::EDGE_FALL:
            begin
                ext_edge = !pins_q[0] && st_r.pin0_prev;
            end
            swi_pkg::EDGE_BOTH:
            begin
                ext_edge = pins_q[0] != st_r.pin0_prev;
            end
            default:
            begin
                // reserved code never triggers
                ext_edge = 1'b0;
            end
        endcase
    end

    // enabled pending requests, taken at an instruction boundary
    assign pend   = (st_r.ext_flag && st_r.ext_en)
                    || (st_r.tmr_flag && st_r.tmr_en);
    // a vector needs the core running and the global enable open
    assign accept = normal && st_r.global_irq_enable && pend && core_evt.boundary;

    // next-state logic
    always_comb
    begin
        // hold all state; strobes fall back to zero each cycle
        st_nxt                    = st_r;
        st_nxt.pin0_prev          = pins_q[0];
        st_nxt.vec.pc_load        = 1'b0;
        st_nxt.vec.stack_push     = 1'b0;
        st_nxt.vec.stack_pop      = 1'b0;
        st_nxt.vec.pc_addr        = swi_pkg::VECTOR_ADDR;
        st_nxt.restore.valid      = 1'b0;

        // power mode sequencing
        case (st_r.mode)
            swi_pkg::MODE_NORMAL:
            begin
                // core halts from the next cycle on
                if (enter_sleep)
                begin
                    st_nxt.sleep_bit = 1'b1;
                    st_nxt.mode      = swi_pkg::MODE_SLEEP;
                end
            end
            swi_pkg::MODE_SLEEP:
            begin
                // only a watched pin change leaves; port 0 pin 0 is always watched
                if (wake_hit)
                begin
                    st_nxt.mode = swi_pkg::MODE_WARMUP;
                    st_nxt.cnt  = '0;
                end
            end
            swi_pkg::MODE_WARMUP:
            begin
                // oscillator settles while the core still waits
                if (st_r.cnt == swi_pkg::WAKE_LAST)
                begin
                    st_nxt.mode      = swi_pkg::MODE_NORMAL;
                    st_nxt.sleep_bit = 1'b0;
                end
                else
                begin
                    st_nxt.cnt = st_r.cnt + 1'b1;
                end
            end
            default:
            begin
                // illegal code: fall back to running
                st_nxt.mode = swi_pkg::MODE_NORMAL;
            end
        endcase

        // register writes; core is halted outside normal mode
        if (normal && reg_bus.wr)
        begin
            // trigger edge of the external pin source
            if (hit(reg_bus.addr, swi_pkg::ADDR_EDGE_SEL))
            begin
                st_nxt.edge_sel = reg_bus.wdata[swi_pkg::EDGE_HI:swi_pkg::EDGE_LO];
            end
            // port 1 wake enables; no read path
            else if (hit(reg_bus.addr, swi_pkg::ADDR_P1_WAKE))
            begin
                st_nxt.p1_wake = reg_bus.wdata[swi_pkg::P1_WAKE_HI:0];
            end
            // request flags; events below still win
            else if (hit(reg_bus.addr, swi_pkg::ADDR_IRQ_REQ))
            begin
                st_nxt.ext_flag = reg_bus.wdata[swi_pkg::EXT_BIT];
                st_nxt.tmr_flag = reg_bus.wdata[swi_pkg::TMR_BIT];
            end
            // per-source enables
            else if (hit(reg_bus.addr, swi_pkg::ADDR_IRQ_EN))
            begin
                st_nxt.ext_en = reg_bus.wdata[swi_pkg::EXT_BIT];
                st_nxt.tmr_en = reg_bus.wdata[swi_pkg::TMR_BIT];
            end
            // global enable and stack level bits
            else if (hit(reg_bus.addr, swi_pkg::ADDR_STACK))
            begin
                st_nxt.global_irq_enable = reg_bus.wdata[swi_pkg::GIE_BIT];
                st_nxt.stk = reg_bus.wdata[swi_pkg::STK_HI:0];
            end
        end

        // events set flags whatever the enables; set wins over a clearing write
        if (ext_edge)
        begin
            st_nxt.ext_flag = 1'b1;
        end
        // timer is stopped in sleep, so only running overflows count
        if (timer_overflow && normal)
        begin
            st_nxt.tmr_flag = 1'b1;
        end

        // return from interrupt re-opens the global enable
        // stack level climbs back by one as the return pops
        if (normal && core_evt.return_from_interrupt)
        begin
            st_nxt.global_irq_enable           = 1'b1;
            st_nxt.stk           = st_r.stk + 1'b1;
            st_nxt.vec.stack_pop = 1'b1;
        end

        // vector acceptance has the last word on the global enable
        // stack level steps down by one as the vector pushes
        if (accept)
        begin
            st_nxt.global_irq_enable            = 1'b0;
            st_nxt.stk            = st_r.stk - 1'b1;
            st_nxt.vec.pc_load    = 1'b1;
            st_nxt.vec.stack_push = 1'b1;
        end

        // single-level save buffer for accumulator and flags
        // a second save overwrites the first
        if (normal && core_evt.push)
        begin
            st_nxt.save_acc   = core_evt.acc;
            st_nxt.save_flags = core_evt.flags & ~swi_pkg::RESET_CAUSE_MASK;
        end
        // restore hands the buffer back with a one-cycle valid
        if (normal && core_evt.pop)
        begin
            st_nxt.restore.valid = 1'b1;
            st_nxt.restore.acc   = st_r.save_acc;
            // reset-cause bits keep their live value
            st_nxt.restore.flags = (st_r.save_flags & ~swi_pkg::RESET_CAUSE_MASK)
                                   | (core_evt.flags & swi_pkg::RESET_CAUSE_MASK);
        end

        // registered read data; write-only and unmapped read zero
        // reads are served in every mode
        if (reg_bus.rd)
        begin
            st_nxt.rdata = 8'h00;
            // edge field
            if (hit(reg_bus.addr, swi_pkg::ADDR_EDGE_SEL))
            begin
                st_nxt.rdata[swi_pkg::EDGE_HI:swi_pkg::EDGE_LO] = st_r.edge_sel;
            end
            // request flags
            else if (hit(reg_bus.addr, swi_pkg::ADDR_IRQ_REQ))
            begin
                st_nxt.rdata[swi_pkg::EXT_BIT] = st_r.ext_flag;
                st_nxt.rdata[swi_pkg::TMR_BIT] = st_r.tmr_flag;
            end
            // per-source enables
            else if (hit(reg_bus.addr, swi_pkg::ADDR_IRQ_EN))
            begin
                st_nxt.rdata[swi_pkg::EXT_BIT] = st_r.ext_en;
                st_nxt.rdata[swi_pkg::TMR_BIT] = st_r.tmr_en;
            end
            // global enable and stack level bits
            else if (hit(reg_bus.addr, swi_pkg::ADDR_STACK))
            begin
                st_nxt.rdata[swi_pkg::GIE_BIT]  = st_r.global_irq_enable;
                st_nxt.rdata[swi_pkg::STK_HI:0] = st_r.stk;
            end
            // sleep bit; reads zero once the core runs again
            else if (hit(reg_bus.addr, swi_pkg::ADDR_OSC_CTRL))
            begin
                st_nxt.rdata[swi_pkg::SLEEP_BIT] = st_r.sleep_bit;
            end
        end
    end

    // state register with documented reset values
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            // clear all, then load mode, edge select, wake enables, stack level and vector
            st_r          <= '0;
            st_r.mode     <= swi_pkg::MODE_NORMAL;
            st_r.edge_sel <= swi_pkg::EDGE_RST;
            st_r.p1_wake  <= swi_pkg::P1_WAKE_RST;
            st_r.stk      <= swi_pkg::STACK_RST;
            st_r.vec      <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // outputs
    assign reg_rdata   = st_r.rdata;
    assign vector_out  = st_r.vec;
    assign restore_out = st_r.restore;

    // power state for the clock generator and the core
    assign osc_run     = (st_r.mode != swi_pkg::MODE_SLEEP);
    assign cpu_run     = normal;

endmodule

// *** core/swi_pkg.sv ***
// constants, modes and carrier types of the sleep, wakeup and interrupt block
// assumes one always-running core clock and the core's byte-wide register port
package swi_pkg;

    // register byte addresses
    localparam logic [7:0] ADDR_EDGE_SEL  = 8'hbf;
    localparam logic [7:0] ADDR_P1_WAKE   = 8'hc0;
    localparam logic [7:0] ADDR_IRQ_REQ   = 8'hc8;
    localparam logic [7:0] ADDR_IRQ_EN    = 8'hc9;
    localparam logic [7:0] ADDR_OSC_CTRL  = 8'hca;
    localparam logic [7:0] ADDR_STACK     = 8'hdf;

    // field positions
    localparam int SLEEP_BIT      = 3;
    localparam int EXT_BIT        = 0;
    localparam int TMR_BIT        = 5;
    localparam int GIE_BIT        = 7;
    localparam int EDGE_LO        = 3;
    localparam int EDGE_HI        = 4;
    localparam int STK_HI         = 1;
    localparam int P1_WAKE_HI     = 5;

    // reset values
    localparam logic [1:0] EDGE_RST    = 2'h2;
    localparam logic [1:0] STACK_RST   = 2'h3;
    localparam logic [5:0] P1_WAKE_RST = 6'h00;

    // trigger edge codes
    localparam logic [1:0] EDGE_RESERVED = 2'h0;
    localparam logic [1:0] EDGE_RISE     = 2'h1;
    localparam logic [1:0] EDGE_FALL     = 2'h2;
    localparam logic [1:0] EDGE_BOTH     = 2'h3;

    // wakeup settle count and vector
    localparam int          WAKE_CLOCKS = 4096;
    localparam int          WAKE_CNT_W  = 12;
    localparam logic [11:0] WAKE_LAST   = 12'(WAKE_CLOCKS - 1);
    localparam int          PC_W        = 12;
    localparam logic [11:0] VECTOR_ADDR = 12'h008;

    // reset-cause flag bits that the save buffer leaves alone
    localparam logic [7:0] RESET_CAUSE_MASK = 8'hc0;

    // pins watched: bit 0 is port 0, bits 6:1 are port 1
    localparam int PIN_W = 7;

    typedef enum logic [2:0]
    {
        MODE_NORMAL = 3'b001,
        MODE_SLEEP  = 3'b010,
        MODE_WARMUP = 3'b100
    } mode_t;

    typedef struct packed
    {
        logic [7:0] addr;
        logic       wr;
        logic       rd;
        logic [7:0] wdata;
    } reg_bus_t;

    typedef struct packed
    {
        logic       boundary;
        logic       return_from_interrupt;
        logic       push;
        logic       pop;
        logic [7:0] acc;
        logic [7:0] flags;
    } core_evt_t;

    typedef struct packed
    {
        logic            pc_load;
        logic [PC_W-1:0] pc_addr;
        logic            stack_push;
        logic            stack_pop;
    } vector_t;

    typedef struct packed
    {
        logic       valid;
        logic [7:0] acc;
        logic [7:0] flags;
    } restore_t;

endpackage

// *** core/pin_sync.sv ***
// three-stage pin synchroniser with a two-stage agreement filter
// assumes pins are asynchronous to core_clk
module pin_sync
(
    input  wire logic                     core_clk,
    input  wire logic                     rst_b,
    input  wire logic [swi_pkg::PIN_W-1:0] pins_async,
    output logic      [swi_pkg::PIN_W-1:0] pins_q
);

    typedef struct packed
    {
        logic [swi_pkg::PIN_W-1:0] s1;
        logic [swi_pkg::PIN_W-1:0] s2;
        logic [swi_pkg::PIN_W-1:0] s3;
        logic [swi_pkg::PIN_W-1:0] q;
    } sync_t;

    sync_t st_r;
    sync_t st_nxt;

    // shift chain; a level counts once stages two and three agree
    always_comb
    begin
        st_nxt    = st_r;
        st_nxt.s1 = pins_async;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        for (int i = 0; i < swi_pkg::PIN_W; i++)
        begin
            if (st_r.s2[i] == st_r.s3[i])
            begin
                st_nxt.q[i] = st_r.s3[i];
            end
        end
    end

    // state register
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign pins_q = st_r.q;

endmodule

// *** core/wake_detect.sv ***
// pin level change detector for wakeup from power-down
// assumes filtered pin levels; reference is caught on the sleep entry pulse
module wake_detect
(
    input  wire logic                      core_clk,
    input  wire logic                      rst_b,
    input  wire logic [swi_pkg::PIN_W-1:0] pins_q,
    input  wire logic [5:0]                p1_wake_en,
    input  wire logic                      capture,
    output logic                           wake_hit
);

    typedef struct packed
    {
        logic [swi_pkg::PIN_W-1:0] ref_lvl;
    } wake_t;

    wake_t                     st_r;
    wake_t                     st_nxt;
    logic [swi_pkg::PIN_W-1:0] watch;

    // latch levels at sleep entry
    always_comb
    begin
        st_nxt = st_r;
        if (capture)
        begin
            st_nxt.ref_lvl = pins_q;
        end
    end

    // port 0 always watched, port 1 per enable
    assign watch    = {p1_wake_en, 1'b1};
    assign wake_hit = |((pins_q ^ st_r.ref_lvl) & watch);

    // state register
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

endmodule

// *** tb/swi_props.sv ***
// checker: sleep, warmup and vector timing seen at the block's ports
// assumes binding onto the top module; a single clock domain
module swi_props
(
    input wire logic               core_clk,
    input wire logic               rst_b,
    input wire swi_pkg::reg_bus_t  reg_bus,
    input wire logic [7:0]         reg_rdata,
    input wire logic               port0_pin,
    input wire logic [5:0]         port1_pins,
    input wire logic               timer_overflow,
    input wire swi_pkg::core_evt_t core_evt,
    input wire swi_pkg::vector_t   vector_out,
    input wire swi_pkg::restore_t  restore_out,
    input wire logic               osc_run,
    input wire logic               cpu_run
);
    timeunit 1ns;
    timeprecision 1ns;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);

    logic [12:0] warm_cnt_r;

    // counts cycles spent with the oscillator up but the core held
    always_ff @(posedge core_clk)
        if (!rst_b || !osc_run || cpu_run)
            warm_cnt_r <= 13'h0000;
        else
            warm_cnt_r <= warm_cnt_r + 13'h0001;

    // sleep, wakeup and vector relations
    a_sleep_entry: assert property (cpu_run && reg_bus.wr && reg_bus.wdata[3] &&
        reg_bus.addr == 8'hca |=> !osc_run && !cpu_run) else $error("sleep entry missed");
    a_osc_stopped: assert property (!osc_run |-> !cpu_run)
        else $error("core runs without oscillator");
    a_no_vector_asleep: assert property (!cpu_run |=> !vector_out.pc_load)
        else $error("vector taken while halted");
    a_warm_length: assert property ($rose(cpu_run) |-> warm_cnt_r == 13'h1000)
        else $error("warmup length wrong");
    a_wo_reads_zero: assert property (reg_bus.rd && reg_bus.addr == 8'hc0 |=>
        reg_rdata == 8'h00) else $error("write-only register read back");
    a_vector_addr: assert property (vector_out.pc_load |->
        vector_out.stack_push && vector_out.pc_addr == 12'h008) else $error("bad vector");
    a_single_take: assert property (vector_out.pc_load |=> !vector_out.pc_load)
        else $error("vector taken twice");
    a_return_from_interrupt_pop: assert property (core_evt.return_from_interrupt && cpu_run |=> vector_out.stack_pop)
        else $error("return without stack pop");
    a_pop_cause: assert property (vector_out.stack_pop |-> $past(core_evt.return_from_interrupt))
        else $error("stack pop without return");
    a_restore_flags: assert property (core_evt.pop && cpu_run |=> restore_out.valid &&
        (restore_out.flags & 8'hc0) == ($past(core_evt.flags) & 8'hc0))
        else $error("restore flags wrong");

    // main scenarios reached
    c_sleep: cover property ($fell(osc_run));
    c_wake: cover property ($rose(cpu_run));
    c_vector: cover property (vector_out.pc_load);
    c_restore: cover property (restore_out.valid);
endmodule

bind sleep_wakeup_interrupt_ctrl swi_props u_props
(
    .core_clk(core_clk), .rst_b(rst_b), .reg_bus(reg_bus), .reg_rdata(reg_rdata),
    .port0_pin(port0_pin), .port1_pins(port1_pins), .timer_overflow(timer_overflow),
    .core_evt(core_evt), .vector_out(vector_out), .restore_out(restore_out),
    .osc_run(osc_run), .cpu_run(cpu_run)
);

// *** tb/core_side_model.sv ***
// far side model: core sequencer pulses and the wake pin levels
// assumes the block's core clock; drives only just after rising edges
module core_side_model
(
    input  wire logic          core_clk,
    input  wire logic          cpu_run,
    output swi_pkg::core_evt_t core_evt,
    output logic               port0_pin,
    output logic [5:0]         port1_pins
);
    timeunit 1ns;
    timeprecision 1ns;

    // quiet sequencer and low pins at start
    initial
    begin
        core_evt = '0;
        port0_pin = 1'b0;
        port1_pins = 6'h00;
    end

    // vectors only offered while the core executes
    always @(posedge core_clk)
        core_evt.boundary <= cpu_run;

    // one-cycle pulse: 0 return, 1 save, 2 restore
    task automatic pulse(input int kind, input logic [7:0] acc, input logic [7:0] flags);
        @(posedge core_clk);
        core_evt.acc <= acc;
        core_evt.flags <= flags;
        core_evt.return_from_interrupt <= (kind == 0);
        core_evt.push <= (kind == 1);
        core_evt.pop <= (kind == 2);
        @(posedge core_clk);
        core_evt.return_from_interrupt <= 1'b0;
        core_evt.push <= 1'b0;
        core_evt.pop <= 1'b0;
        core_evt.acc <= ~acc; // inverted data once the pulse is gone
        core_evt.flags <= ~flags;
    endtask

    // new pin levels, held until changed again
    task automatic pins(input logic p0, input logic [5:0] p1);
        @(posedge core_clk);
        port0_pin <= p0;
        port1_pins <= p1;
    endtask
endmodule

// *** tb/tb_sleep_wakeup_interrupt_ctrl.sv ***
// self-checking bench for the sleep, wakeup and interrupt block
// assumes the checker binds itself; the core side model drives pins and pulses
module tb_sleep_wakeup_interrupt_ctrl;
    timeunit 1ns;
    timeprecision 1ns;

    logic               core_clk = 1'b0;
    logic               rst_b = 1'b0;
    swi_pkg::reg_bus_t  reg_bus = '0;
    logic               timer_overflow = 1'b0;
    logic [7:0]         reg_rdata;
    logic               port0_pin;
    logic [5:0]         port1_pins;
    logic               osc_run;
    logic               cpu_run;
    swi_pkg::core_evt_t core_evt;
    swi_pkg::vector_t   vector_out;
    swi_pkg::restore_t  restore_out;
    int                 fails = 0;
    int                 checks_done = 0;
    int                 vec_cnt = 0;

    always #50 core_clk = ~core_clk;

    // counts vector loads
    always @(posedge core_clk)
        if (vector_out.pc_load === 1'b1)
            vec_cnt <= vec_cnt + 1;

    sleep_wakeup_interrupt_ctrl DUT
    (
        .core_clk(core_clk), .rst_b(rst_b), .reg_bus(reg_bus), .reg_rdata(reg_rdata),
        .port0_pin(port0_pin), .port1_pins(port1_pins), .timer_overflow(timer_overflow),
        .core_evt(core_evt), .vector_out(vector_out), .restore_out(restore_out),
        .osc_run(osc_run), .cpu_run(cpu_run)
    );

    core_side_model model
    (
        .core_clk(core_clk), .cpu_run(cpu_run), .core_evt(core_evt),
        .port0_pin(port0_pin), .port1_pins(port1_pins)
    );

    task automatic results();
        $display("checks=%0d fails=%0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_bus.addr <= a;
        reg_bus.wdata <= d;
        reg_bus.wr <= 1'b1;
        @(posedge core_clk);
        reg_bus.wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        reg_bus.addr <= a;
        reg_bus.rd <= 1'b1;
        @(posedge core_clk);
        reg_bus.rd <= 1'b0;
        #1;
        check({8'h00, reg_rdata}, {8'h00, exp});
    endtask

    // bounded wait for osc_run (osc=1) or cpu_run to go high; n counts edges
    task automatic wait_hi(input bit osc, input int lim, output int n);
        n = 0;
        do
        begin
            @(posedge core_clk);
            #1;
            n++;
        end
        while ((osc ? osc_run : cpu_run) !== 1'b1 && n < lim);
        if ((osc ? osc_run : cpu_run) !== 1'b1)
        begin
            fails++;
            results();
        end
    endtask

    task automatic t_regs();
        rd(8'hbf, 8'h10);
        rd(8'hc0, 8'h00);
        rd(8'hc8, 8'h00);
        rd(8'hc9, 8'h00);
        rd(8'hca, 8'h00);
        rd(8'hdf, 8'h03);
        rd(8'h00, 8'h00);
        wr(8'hc9, 8'hff);
        rd(8'hc9, 8'h21);
        wr(8'hc0, 8'h3f);
        rd(8'hc0, 8'h00);
        wr(8'hc9, 8'h00);
    endtask

    // every trigger code against a rise and a fall of the pin
    task automatic t_edges();
        for (int m = 0; m < 4; m++)
        begin
            wr(8'hbf, 8'(m << 3));
            model.pins(1'b1, port1_pins);
            repeat (8) @(posedge core_clk);
            rd(8'hc8, {7'h00, m[0]});
            wr(8'hc8, 8'h00);
            model.pins(1'b0, port1_pins);
            repeat (8) @(posedge core_clk);
            rd(8'hc8, {7'h00, m[1]});
            wr(8'hc8, 8'h00);
        end
    endtask

    // flag set while disabled, vector once enabled, return restores enable
    task automatic t_vector(input bit pin);
        int base;
        logic [7:0] bit_v;
        base = vec_cnt;
        bit_v = pin ? 8'h01 : 8'h20;
        wr(8'hdf, 8'h83);
        if (pin)
            model.pins(~port0_pin, port1_pins);
        else
            wr(8'hc8, 8'h00);
        timer_overflow <= !pin;
        @(posedge core_clk);
        timer_overflow <= 1'b0;
        repeat (8) @(posedge core_clk);
        rd(8'hc8, bit_v);
        check(16'(vec_cnt - base), 16'h0000);
        wr(8'hc9, bit_v);
        for (int i = 0; i < 10 && vec_cnt == base; i++)
            @(posedge core_clk);
        check(16'(vec_cnt - base), 16'h0001);
        if (vec_cnt == base)
        begin
            results();
        end
        rd(8'hdf, 8'h02);
        wr(8'hc8, 8'h00);
        model.pulse(0, 8'h00, 8'h00);
        rd(8'hdf, 8'h83);
        check(16'(vec_cnt - base), 16'h0001);
        wr(8'hdf, 8'h03);
        wr(8'hc9, 8'h00);
    endtask

    task automatic t_save();
        model.pulse(1, 8'h5a, 8'hff);
        model.pulse(1, 8'ha5, 8'h81);
        model.pulse(2, 8'h00, 8'h40);
        #1;
        check({restore_out.acc, restore_out.flags}, 16'ha541);
    endtask

    // sleep held against timer, disabled pin and writes; woken by pins
    task automatic t_sleep();
        int n;
        wr(8'hc0, 8'h01);
        wr(8'hbf, 8'h18);
        wr(8'hca, 8'h08);
        #1;
        check({14'h0000, osc_run, cpu_run}, 16'h0000);
        wr(8'hc9, 8'h21);
        timer_overflow <= 1'b1;
        @(posedge core_clk);
        timer_overflow <= 1'b0;
        model.pins(port0_pin, port1_pins ^ 6'h02);
        repeat (10) @(posedge core_clk);
        #1;
        check({15'h0000, osc_run}, 16'h0000);
        model.pins(port0_pin, port1_pins ^ 6'h01);
        wait_hi(1'b1, 10, n);
        wait_hi(1'b0, 5000, n);
        check(16'(n), 16'h1000);
        rd(8'hca, 8'h00);
        rd(8'hc9, 8'h00);
        wr(8'hca, 8'h08);
        model.pins(~port0_pin, port1_pins);
        wait_hi(1'b1, 10, n);
        wait_hi(1'b0, 5000, n);
        rd(8'hc8, 8'h01);
    endtask

    initial
    begin
        repeat (5) @(posedge core_clk);
        rst_b <= 1'b1;
        repeat (6) @(posedge core_clk);
        t_regs();
        t_edges();
        t_vector(1'b0);
        t_vector(1'b1);
        t_save();
        t_sleep();
        results();
    end
endmodule
